// [include/cmis_pkg.sv]
package cmis_pkg;
    // =====================================================================
    // register map
    // =====================================================================
    localparam logic [7:0] MODE_ADDR       = 8'h9D;
    localparam logic [7:0] INSEL_ADDR      = 8'h9F;
    localparam logic [7:0] MODE_RESET      = 8'h02;
    localparam logic [7:0] INSEL_RESET     = 8'hFF;
    localparam logic [7:0] MODE_WR_MASK    = 8'h33;
    localparam int         RISE_IE_BIT     = 5;
    localparam int         FALL_IE_BIT     = 4;
    localparam int         MODE_LSB        = 0;
    localparam int         NEG_LSB         = 4;
    localparam int         POS_LSB         = 0;
    localparam int         CODE_W          = 4;
    localparam int         PIN_COUNT       = 8;
    localparam logic [3:0] CODE_REG_TAP    = 4'h8;
    localparam logic [3:0] CODE_RSV_LO     = 4'h6;

    typedef enum logic [1:0]
    {
        MODE_FASTEST,
        MODE_ONE,
        MODE_TWO,
        MODE_SLOWEST
    } cmis_mode_t;
endpackage

// [verilog/cmis_input_decode.sv]
module cmis_input_decode
#(
    parameter int PINS     = 8,
    parameter bit SMALL    = 1'b0
)
(
    input  wire logic [3:0]      code,
    output logic      [PINS-1:0] pin_sel,
    output logic                 tap_sel
);
    import cmis_pkg::*;

    // the code field has room for eight pin codes below the regulator tap
    if (PINS != PIN_COUNT)
    begin : g_pins_chk
        $error("cmis_input_decode: PINS must equal %0d", PIN_COUNT);
    end

    // =====================================================================
    // one-hot pin select; reserved codes on the small package connect nothing
    // =====================================================================
    genvar g;
    generate
        for (g = 0; g < PINS; g++)
        begin : g_pin
            assign pin_sel[g] = (code == 4'(g)) && !(SMALL && (4'(g) >= CODE_RSV_LO));
        end
    endgenerate

    assign tap_sel = (code == CODE_REG_TAP);
endmodule

// [verilog/cmis_regs.sv]
// Summary of operation
// - mode register bits 7:6 and 3:2 read as zero and ignore writes.
// - mode bit 5 enables the rising-edge flag onto the interrupt request.
// - mode bit 4 enables the falling-edge flag onto the interrupt request.
// - mode bits 1:0 drive the response-time/power code to the comparator, 00 fastest, 11 slowest.
// - input-select bits 3:0 pick the positive input: pin n at code n for 0-7 (0-5 with SMALL_PACKAGE), regulator tap at 1000, none above.
// - each comparator output edge sets its sticky flag, which stays set until software clears it.
module cmis_regs
#(
    parameter bit SMALL_PACKAGE = 1'b0
)
(
    input  wire logic                         CLK,
    input  wire logic                         SRST,
    input  wire logic [7:0]                   SFR_ADDR,
    input  wire logic                         SFR_WE,
    input  wire logic [7:0]                   SFR_WDATA,
    output logic      [7:0]                   SFR_RDATA,
    input  wire logic                         CMP_OUT,
    input  wire logic                         RISE_FLAG_CLR,
    input  wire logic                         FALL_FLAG_CLR,
    output logic                              RISE_SEEN_FLAG,
    output logic                              FALL_SEEN_FLAG,
    output cmis_pkg::cmis_mode_t              RESPONSE_MODE_CODE,
    output logic      [cmis_pkg::PIN_COUNT-1:0] NEG_PIN_SEL,
    output logic                              NEG_TAP_SEL,
    output logic      [cmis_pkg::PIN_COUNT-1:0] POS_PIN_SEL,
    output logic                              POS_TAP_SEL,
    output logic                              CMP_IRQ
);
    import cmis_pkg::*;

    // =====================================================================
    // register state
    // =====================================================================
    logic [7:0] mode_q;
    logic [7:0] mode_d;
    logic [7:0] insel_q;
    logic [7:0] insel_d;
    logic       cmp_q;
    logic       cmp_d;
    logic       seen_q;
    logic       seen_d;
    logic       rise_q;
    logic       rise_d;
    logic       fall_q;
    logic       fall_d;
    logic [7:0] rdata_q;
    logic [7:0] rdata_d;
    logic       rise_edge;
    logic       fall_edge;

    function automatic logic hit(input logic [7:0] a, input logic [7:0] reg_addr);
        hit = (a == reg_addr);
    endfunction

    always_comb
    begin
        mode_d  = mode_q;
        insel_d = insel_q;
        if (SFR_WE && hit(SFR_ADDR, MODE_ADDR))
            mode_d = SFR_WDATA & MODE_WR_MASK;
        else if (SFR_WE && hit(SFR_ADDR, INSEL_ADDR))
            insel_d = SFR_WDATA;
    end

    // =====================================================================
    // edge flags; the first sample after reset only primes the history
    // =====================================================================
    assign rise_edge = seen_q && CMP_OUT && !cmp_q;
    assign fall_edge = seen_q && !CMP_OUT && cmp_q;

    always_comb
    begin
        cmp_d  = CMP_OUT;
        seen_d = 1'b1;
        // set beats a clear landing in the same cycle, so no edge is lost
        rise_d = rise_edge | (rise_q & ~RISE_FLAG_CLR);
        fall_d = fall_edge | (fall_q & ~FALL_FLAG_CLR);
    end

    always_comb
    begin
        rdata_d = 8'h00;
        if (hit(SFR_ADDR, MODE_ADDR))
            rdata_d = mode_q & MODE_WR_MASK;
        else if (hit(SFR_ADDR, INSEL_ADDR))
            rdata_d = insel_q;
    end

    always_ff @(posedge CLK)
    begin
        if (SRST)
        begin
            mode_q  <= MODE_RESET;
            insel_q <= INSEL_RESET;
            cmp_q   <= 1'b0;
            seen_q  <= 1'b0;
            rise_q  <= 1'b0;
            fall_q  <= 1'b0;
            rdata_q <= 8'h00;
        end
        else
        begin
            mode_q  <= mode_d;
            insel_q <= insel_d;
            cmp_q   <= cmp_d;
            seen_q  <= seen_d;
            rise_q  <= rise_d;
            fall_q  <= fall_d;
            rdata_q <= rdata_d;
        end
    end

    // =====================================================================
    // outputs to the analog comparator and interrupt controller
    // =====================================================================
    assign SFR_RDATA          = rdata_q;
    assign RISE_SEEN_FLAG     = rise_q;
    assign FALL_SEEN_FLAG     = fall_q;
    assign RESPONSE_MODE_CODE = cmis_mode_t'(mode_q[MODE_LSB +: 2]);
    assign CMP_IRQ = (rise_q & mode_q[RISE_IE_BIT]) | (fall_q & mode_q[FALL_IE_BIT]);

    // pins selected here must be analog and crossbar-skipped by software
    cmis_input_decode #(.PINS(PIN_COUNT), .SMALL(SMALL_PACKAGE)) u_neg
    (
        .code    (insel_q[NEG_LSB +: CODE_W]),
        .pin_sel (NEG_PIN_SEL),
        .tap_sel (NEG_TAP_SEL)
    );

    cmis_input_decode #(.PINS(PIN_COUNT), .SMALL(SMALL_PACKAGE)) u_pos
    (
        .code    (insel_q[POS_LSB +: CODE_W]),
        .pin_sel (POS_PIN_SEL),
        .tap_sel (POS_TAP_SEL)
    );

    // =====================================================================
    // elaboration check: pin codes must stay below the regulator tap code
    // =====================================================================
    if (PIN_COUNT > int'(CODE_REG_TAP))
    begin : g_code_chk
        $error("cmis_regs: pin codes overlap the regulator tap code");
    end

    // =====================================================================
    // checks
    // =====================================================================
    reserved_zero_a: assert property (@(posedge CLK) disable iff (SRST)
        (mode_q[7:6] == 2'b00) && (mode_q[3:2] == 2'b00)) else $error("mode reserved bits set");
    rise_gate_a: assert property (@(posedge CLK) disable iff (SRST)
        (rise_q && mode_q[RISE_IE_BIT]) |-> CMP_IRQ) else $error("rise irq missing");
    fall_gate_a: assert property (@(posedge CLK) disable iff (SRST)
        (fall_q && mode_q[FALL_IE_BIT]) |-> CMP_IRQ) else $error("fall irq missing");
    mode_write_a: assert property (@(posedge CLK) disable iff (SRST)
        (SFR_WE && SFR_ADDR == MODE_ADDR) |=> (RESPONSE_MODE_CODE == $past(SFR_WDATA[1:0])))
        else $error("mode code not taken");
    neg_tap_a: assert property (@(posedge CLK) disable iff (SRST)
        (insel_q[7:4] == CODE_REG_TAP) |-> (NEG_TAP_SEL && NEG_PIN_SEL == '0)) else $error("neg tap");
    pos_none_a: assert property (@(posedge CLK) disable iff (SRST)
        (insel_q[3:0] > CODE_REG_TAP) |-> (!POS_TAP_SEL && POS_PIN_SEL == '0)) else $error("pos none");
    rise_set_a: assert property (@(posedge CLK) disable iff (SRST)
        (seen_q && CMP_OUT && !cmp_q) |=> RISE_SEEN_FLAG) else $error("rise flag lost");
    flag_sticky_a: assert property (@(posedge CLK) disable iff (SRST)
        (FALL_SEEN_FLAG && !FALL_FLAG_CLR) |=> FALL_SEEN_FLAG) else $error("fall flag dropped");
    irq_quiet_a: assert property (@(posedge CLK) disable iff (SRST)
        (!mode_q[RISE_IE_BIT] && !mode_q[FALL_IE_BIT]) |-> !CMP_IRQ) else $error("irq while masked");

    // =====================================================================
    // register bus checks
    // =====================================================================
    mode_rdata_a: assert property (@(posedge CLK) disable iff (SRST)
        (!$past(SRST) && $past(SFR_ADDR) == MODE_ADDR) |-> (SFR_RDATA[7:6] == 2'b00 && SFR_RDATA[3:2] == 2'b00))
        else $error("mode reserved bits read back");
    insel_rdata_a: assert property (@(posedge CLK) disable iff (SRST)
        (!$past(SRST) && $past(SFR_ADDR) == INSEL_ADDR) |-> (SFR_RDATA == $past(insel_q)))
        else $error("input select read back wrong");
    insel_write_a: assert property (@(posedge CLK) disable iff (SRST)
        (SFR_WE && SFR_ADDR == INSEL_ADDR) |=> (insel_q == $past(SFR_WDATA)))
        else $error("input select write lost");
    enable_write_a: assert property (@(posedge CLK) disable iff (SRST)
        (SFR_WE && SFR_ADDR == MODE_ADDR) |=> (mode_q[5:4] == $past(SFR_WDATA[5:4])))
        else $error("edge enables not taken");
    code_stable_a: assert property (@(posedge CLK) disable iff (SRST)
        !(SFR_WE && SFR_ADDR == MODE_ADDR) |=> $stable(RESPONSE_MODE_CODE))
        else $error("mode code moved without a write");

    // =====================================================================
    // edge flag checks
    // =====================================================================
    fall_set_a: assert property (@(posedge CLK) disable iff (SRST)
        (seen_q && !CMP_OUT && cmp_q) |=> FALL_SEEN_FLAG)
        else $error("fall flag not set");
    rise_sticky_a: assert property (@(posedge CLK) disable iff (SRST)
        (RISE_SEEN_FLAG && !RISE_FLAG_CLR) |=> RISE_SEEN_FLAG)
        else $error("rise flag dropped");
    rise_clear_a: assert property (@(posedge CLK) disable iff (SRST)
        (RISE_FLAG_CLR && !(seen_q && CMP_OUT && !cmp_q)) |=> !RISE_SEEN_FLAG)
        else $error("rise flag not cleared");
    fall_clear_a: assert property (@(posedge CLK) disable iff (SRST)
        (FALL_FLAG_CLR && !(seen_q && !CMP_OUT && cmp_q)) |=> !FALL_SEEN_FLAG)
        else $error("fall flag not cleared");
    irq_source_a: assert property (@(posedge CLK) disable iff (SRST)
        CMP_IRQ |-> ((RISE_SEEN_FLAG && mode_q[RISE_IE_BIT]) || (FALL_SEEN_FLAG && mode_q[FALL_IE_BIT])))
        else $error("irq without an enabled flag");

    // =====================================================================
    // input select checks; codes 6 and 7 name pins only on larger packages
    // =====================================================================
    neg_none_a: assert property (@(posedge CLK) disable iff (SRST)
        (insel_q[7:4] > CODE_REG_TAP) |-> (!NEG_TAP_SEL && NEG_PIN_SEL == '0))
        else $error("neg none");
    pos_tap_a: assert property (@(posedge CLK) disable iff (SRST)
        (insel_q[3:0] == CODE_REG_TAP) |-> (POS_TAP_SEL && POS_PIN_SEL == '0))
        else $error("pos tap");
    neg_pick_a: assert property (@(posedge CLK) disable iff (SRST)
        (insel_q[7:4] < CODE_RSV_LO) |-> (NEG_PIN_SEL == (PIN_COUNT'(1) << insel_q[7:4]) && !NEG_TAP_SEL))
        else $error("neg pin pick");
    pos_pick_a: assert property (@(posedge CLK) disable iff (SRST)
        (insel_q[3:0] < CODE_RSV_LO) |-> (POS_PIN_SEL == (PIN_COUNT'(1) << insel_q[3:0]) && !POS_TAP_SEL))
        else $error("pos pin pick");
    small_neg_a: assert property (@(posedge CLK) disable iff (SRST)
        (SMALL_PACKAGE && insel_q[7:4] >= CODE_RSV_LO && insel_q[7:4] < CODE_REG_TAP) |-> (NEG_PIN_SEL == '0))
        else $error("neg reserved code picked a pin");
    small_pos_a: assert property (@(posedge CLK) disable iff (SRST)
        (SMALL_PACKAGE && insel_q[3:0] >= CODE_RSV_LO && insel_q[3:0] < CODE_REG_TAP) |-> (POS_PIN_SEL == '0))
        else $error("pos reserved code picked a pin");
endmodule

// [dv/tb_comparator_mode_and_input_select.sv]
module tb_comparator_mode_and_input_select;
    timeunit 1ns;
    timeprecision 1ps;
    import cmis_pkg::*;

    logic       clk;
    logic       srst;
    logic       we;
    logic       cmp;
    logic       rclr;
    logic       fclr;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic [7:0] npin;
    logic [7:0] ppin;
    logic [7:0] npin_s;
    logic [7:0] ppin_s;
    logic       rise_f;
    logic       fall_f;
    logic       ntap;
    logic       ptap;
    logic       irq;
    cmis_mode_t mcode;
    logic [8:0] e;
    int         fails = 0;
    int         compares = 0;
    int         cycles = 0;

    cmis_regs uut (.CLK(clk), .SRST(srst), .SFR_ADDR(addr), .SFR_WE(we), .SFR_WDATA(wdata), .SFR_RDATA(rdata),
        .CMP_OUT(cmp), .RISE_FLAG_CLR(rclr), .FALL_FLAG_CLR(fclr), .RISE_SEEN_FLAG(rise_f),
        .FALL_SEEN_FLAG(fall_f), .RESPONSE_MODE_CODE(mcode), .NEG_PIN_SEL(npin), .NEG_TAP_SEL(ntap),
        .POS_PIN_SEL(ppin), .POS_TAP_SEL(ptap), .CMP_IRQ(irq));

    // second copy in the small package, where codes 6 and 7 connect nothing
    cmis_regs #(.SMALL_PACKAGE(1'b1)) uut_small (.CLK(clk), .SRST(srst), .SFR_ADDR(addr), .SFR_WE(we),
        .SFR_WDATA(wdata), .SFR_RDATA(), .CMP_OUT(cmp), .RISE_FLAG_CLR(rclr), .FALL_FLAG_CLR(fclr),
        .RISE_SEEN_FLAG(), .FALL_SEEN_FLAG(), .RESPONSE_MODE_CODE(), .NEG_PIN_SEL(npin_s), .NEG_TAP_SEL(),
        .POS_PIN_SEL(ppin_s), .POS_TAP_SEL(), .CMP_IRQ());

    // =========================================================
    // clock, hang guard
    // =========================================================
    initial
    begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    always @(posedge clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 3000)
        begin
            fails = fails + 1;
            finish_test();
        end
    end

    // =========================================================
    // access tasks
    // =========================================================
    task finish_test();
        if (fails == 0 && compares > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    task chk(input logic [7:0] got, input logic [7:0] exp);
        compares = compares + 1;
        if (got !== exp)
        begin
            fails = fails + 1;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // every task starts just after an edge, so the next edge takes the request
    task wr(input logic [7:0] a, input logic [7:0] d);
        addr = a;
        wdata = d;
        we = 1'b1;
        @(posedge clk);
        #1;
        we = 1'b0;
    endtask

    task rd(input logic [7:0] a, input logic [7:0] x);
        addr = a;
        @(posedge clk);
        #1;
        chk(rdata, x);
    endtask

    // the flag sets at the first edge; the second edge shows that it stays
    task edge_chk(input logic v, input logic er, input logic ef, input logic ei);
        cmp = v;
        repeat (2) @(posedge clk);
        #1;
        chk({6'h00, rise_f, fall_f}, {6'h00, er, ef});
        chk({7'h00, irq}, {7'h00, ei});
    endtask

    function automatic logic [8:0] sel(input logic [3:0] c);
        sel = {c == 4'h8, (c < 4'h8) ? (8'h01 << c) : 8'h00};
    endfunction

    // =========================================================
    // main sequence
    // =========================================================
    initial
    begin
        {srst, we, cmp, rclr, fclr, addr, wdata} = {1'b1, 20'h00000};
        repeat (16) @(posedge clk);
        #1;
        srst = 1'b0;
        rd(MODE_ADDR, 8'h02);
        chk({6'h00, mcode}, 8'h02);
        rd(INSEL_ADDR, 8'hFF);
        chk(npin | ppin, 8'h00);
        chk({6'h00, ntap, ptap}, 8'h00);
        wr(MODE_ADDR, 8'hFF);
        rd(MODE_ADDR, 8'h33);
        wr(8'h9E, 8'hAA);
        rd(8'h9E, 8'h00);
        rd(INSEL_ADDR, 8'hFF);
        for (int i = 0; i < 4; i++)
        begin
            wr(MODE_ADDR, 8'hCC | i[7:0]);
            chk({6'h00, mcode}, i[7:0]);
            rd(MODE_ADDR, i[7:0]);
        end
        for (int k = 0; k < 16; k++)
        begin
            wr(INSEL_ADDR, {k[3:0], ~k[3:0]});
            rd(INSEL_ADDR, {k[3:0], ~k[3:0]});
            e = sel(k[3:0]);
            chk(npin, e[7:0]);
            chk(npin_s, e[7:0] & 8'h3F);
            chk({7'h00, ntap}, {7'h00, e[8]});
            e = sel(~k[3:0]);
            chk(ppin, e[7:0]);
            chk(ppin_s, e[7:0] & 8'h3F);
            chk({7'h00, ptap}, {7'h00, e[8]});
        end
        wr(MODE_ADDR, 8'h20);
        edge_chk(1'b1, 1'b1, 1'b0, 1'b1);
        edge_chk(1'b0, 1'b1, 1'b1, 1'b1);
        wr(MODE_ADDR, 8'h00);
        chk({7'h00, irq}, 8'h00);
        {rclr, fclr} = 2'b11;
        @(posedge clk);
        #1;
        {rclr, fclr} = 2'b00;
        chk({6'h00, rise_f, fall_f}, 8'h00);
        wr(MODE_ADDR, 8'h10);
        edge_chk(1'b1, 1'b1, 1'b0, 1'b0);
        edge_chk(1'b0, 1'b1, 1'b1, 1'b1);
        repeat (5) @(posedge clk);
        #1;
        chk({6'h00, rise_f, fall_f}, 8'h03);
        // a clear landing on a new rising edge must lose to the set
        {rclr, fclr} = 2'b11;
        cmp = 1'b1;
        @(posedge clk);
        #1;
        {rclr, fclr} = 2'b00;
        chk({6'h00, rise_f, fall_f}, 8'h02);
        chk({7'h00, irq}, 8'h00);
        // mid-run reset with the comparator high: no false rising edge may follow
        srst = 1'b1;
        repeat (2) @(posedge clk);
        #1;
        srst = 1'b0;
        rd(MODE_ADDR, 8'h02);
        chk({6'h00, mcode}, 8'h02);
        chk({6'h00, rise_f, fall_f}, 8'h00);
        edge_chk(1'b0, 1'b0, 1'b1, 1'b0);
        finish_test();
    end
endmodule
